// File: transfer_controller_activation_regs.sv
/*
 Activation enables, control/status and information base register of the
 transfer controller, reached over a classic Wishbone slave.
 Assumes: the transfer sequencer, interrupt sources and the NMI/address
 error events all run on clk_i; power-on reset is rst_i, standby entry
 and manual reset are same-clock levels from the system controller.
*/
`timescale 1ns/1ns
`default_nettype none
module transfer_controller_activation_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic standby_i,
   input wire logic manual_rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Interrupt sources and system events
   input wire logic [transfer_controller_pkg::SRC_NUM-1:0] src_req_i,
   input wire logic [transfer_controller_pkg::SRC_NUM-1:0] src_irq_passed_i,
   input wire logic nmi_i,
   input wire logic addr_err_i,
   // Sequencer status
   input wire logic busy_i,
   input wire logic nmi_continue_mode_i,
   input wire logic soft_req_i,
   input wire logic soft_done_i,
   input wire logic soft_transfer_done_irq_i,
   input wire logic [15:0] blk_len_word_i,
   // Towards the sequencer
   output logic [transfer_controller_pkg::SRC_NUM-1:0] start_o,
   output logic soft_start_o,
   output logic abort_o,
   output logic [15:0] soft_vec_addr_o,
   output logic [15:0] info_base_upper_o,
   output logic [16:0] block_count_o
);
   import transfer_controller_pkg::*;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [EN_REGS-1:0][EN_BITS-1:0] en;
      logic [EN_REGS-1:0][EN_BITS-1:0] en_snap;
      logic [EN_REGS-1:0] en_snap_v;
      logic nmi_seen_flag;
      logic addr_error_flag;
      logic soft_start_enable;
      logic [7:0] soft_vector_field;
      logic [2:0] csr_snap;
      logic csr_snap_v;
      logic [15:0] base;
      logic [SRC_NUM-1:0] start;
      logic soft_start;
      logic abort;
      logic [15:0] soft_vaddr;
      logic [16:0] blk_cnt;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic req;
   logic rd;
   logic wr;
   logic blocked;
   logic [SRC_NUM-1:0] en_flat;
   logic [15:0] csr_view;

   // New bus request: one answer per held request
   assign req = cyc_i & stb_i & ~s_q.ack;
   assign rd = req & ~we_i;
   assign wr = req & we_i;

   // Starts are refused while either flag stands or is being raised
   assign blocked = s_q.nmi_seen_flag | s_q.addr_error_flag | nmi_i | addr_err_i;

   // Flat view of the enables, register A bit 0 is source 0
   assign en_flat = s_q.en;

   // Control/status as software sees it
   assign csr_view = {5'b0_0000, s_q.nmi_seen_flag, s_q.addr_error_flag,
                      s_q.soft_start_enable, s_q.soft_vector_field};

   // Next-state logic for bus, registers and outputs
   always_comb begin
      logic [31:0] rsel;
      logic [7:0] wb0;
      logic [7:0] wb1;
      rsel = 32'h0000_0000;
      wb0 = dat_i[7:0];
      wb1 = dat_i[15:8];
      s_d = s_q;
      s_d.ack = req;

      // Read multiplexer; unmapped words answer zero
      unique case (adr_i)
         OFS_EN_A: rsel = {24'h00_0000, s_q.en[0]};
         OFS_EN_B: rsel = {24'h00_0000, s_q.en[1]};
         OFS_EN_C: rsel = {24'h00_0000, s_q.en[2]};
         OFS_EN_D: rsel = {24'h00_0000, s_q.en[3]};
         OFS_EN_E: rsel = {24'h00_0000, s_q.en[4]};
         OFS_CSR: rsel = {16'h0000, csr_view};
         OFS_BASE: rsel = {16'h0000, s_q.base};
         default: rsel = 32'h0000_0000;
      endcase
      if (rd) begin
         s_d.rdat = rsel;
      end

      // Hardware clear of a source whose interrupt went to the CPU
      for (int r = 0; r < EN_REGS; r++) begin
         s_d.en[r] = s_q.en[r] & ~src_irq_passed_i[r*EN_BITS +: EN_BITS];
      end

      // Enable registers: snapshot on read, change only the opposite bits
      for (int r = 0; r < EN_REGS; r++) begin
         if (adr_i == OFS_EN_A + 8'(4 * r)) begin
            if (rd) begin
               s_d.en_snap[r] = s_q.en[r];
               s_d.en_snap_v[r] = 1'b1;
            end
            if (wr && sel_i[0]) begin
               if (s_q.en_snap_v[r]) begin
                  for (int b = 0; b < EN_BITS; b++) begin
                     if (wb0[b] != s_q.en_snap[r][b]) begin
                        s_d.en[r][b] = wb0[b];
                     end
                  end
               end
               s_d.en_snap_v[r] = 1'b0;
            end
         end
      end

      // Status flags are raised by hardware events
      if (nmi_i) begin
         s_d.nmi_seen_flag = 1'b1;
      end
      if (addr_err_i) begin
         s_d.addr_error_flag = 1'b1;
      end

      // Soft enable dropped after a soft transfer without done interrupt
      if (soft_done_i && !soft_transfer_done_irq_i) begin
         s_d.soft_start_enable = 1'b0;
      end

      // Control/status write and read snapshot
      if (adr_i == OFS_CSR) begin
         if (rd) begin
            s_d.csr_snap = {s_q.nmi_seen_flag, s_q.addr_error_flag,
                            s_q.soft_start_enable};
            s_d.csr_snap_v = 1'b1;
         end
         if (wr) begin
            if (sel_i[1]) begin
               // Flags: zero after reading one clears; events still win
               if (s_q.csr_snap_v && s_q.csr_snap[2] && !wb1[CSR_NMI_POS-8]
                   && !nmi_i) begin
                  s_d.nmi_seen_flag = 1'b0;
               end
               if (s_q.csr_snap_v && s_q.csr_snap[1] && !wb1[CSR_AE_POS-8]
                   && !addr_err_i) begin
                  s_d.addr_error_flag = 1'b0;
               end
               // Soft enable: one always taken, zero only after reading one
               if (wb1[CSR_SWEN_POS-8]) begin
                  s_d.soft_start_enable = 1'b1;
               end else if (s_q.csr_snap_v && s_q.csr_snap[0]) begin
                  s_d.soft_start_enable = 1'b0;
               end
            end
            if (sel_i[0] && !s_q.soft_start_enable) begin
               s_d.soft_vector_field = wb0;
            end
            s_d.csr_snap_v = 1'b0;
         end
      end

      // Information base, per byte lane; byte writes are the user's risk
      if (wr && adr_i == OFS_BASE) begin
         if (sel_i[0]) begin
            s_d.base[7:0] = wb0;
         end
         if (sel_i[1]) begin
            s_d.base[15:8] = wb1;
         end
      end

      // Standby entry clears enables and control/status
      if (standby_i) begin
         for (int r = 0; r < EN_REGS; r++) begin
            s_d.en[r] = EN_RST;
         end
         {s_d.nmi_seen_flag, s_d.addr_error_flag, s_d.soft_start_enable,
          s_d.soft_vector_field} = CSR_RST[10:0];
         s_d.en_snap_v = '0;
         s_d.csr_snap_v = 1'b0;
      end

      // Activation requests towards the sequencer
      s_d.start = src_req_i & en_flat & {SRC_NUM{~blocked}};
      s_d.soft_start = soft_req_i & s_q.soft_start_enable & ~blocked;
      // An NMI stops a running transfer unless it runs in continue mode
      s_d.abort = nmi_i & busy_i & ~nmi_continue_mode_i;
      // Two-byte entry fetched from origin plus vector field
      s_d.soft_vaddr = SOFT_VEC_ORIGIN + {8'h00, s_q.soft_vector_field};
      // Block length word decoded to a count
      s_d.blk_cnt = (blk_len_word_i == BLK_LEN_WRAP_CODE) ? BLK_LEN_WRAP_COUNT
                    : {1'b0, blk_len_word_i};

      // Manual reset stops pulses but keeps the registers
      if (manual_rst_i) begin
         s_d.start = '0;
         s_d.soft_start = 1'b0;
         s_d.abort = 1'b0;
      end
   end

   // State register; the base register keeps its contents through reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.base <= s_q.base;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign ack_o = s_q.ack;
   assign dat_o = s_q.rdat;
   assign start_o = s_q.start;
   assign soft_start_o = s_q.soft_start;
   assign abort_o = s_q.abort;
   assign soft_vec_addr_o = s_q.soft_vaddr;
   assign info_base_upper_o = s_q.base;
   assign block_count_o = s_q.blk_cnt;

   // Helper: reset delayed by one cycle, so checks skip the release edge
   logic rst_q;
   always_ff @(posedge clk_i) begin
      rst_q <= rst_i;
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || rst_q);

   // Helper: the read answered in this cycle was to control/status
   logic csr_rd_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         csr_rd_q <= 1'b0;
      end else begin
         csr_rd_q <= rd && adr_i == OFS_CSR;
      end
   end

   chk_blk_wrap: assert property (
      blk_len_word_i == 16'h0000 && !manual_rst_i |=> block_count_o == 17'h1_0000)
      else $error("zero block length not decoded as 65536");
   chk_blk_plain: assert property (
      blk_len_word_i != 16'h0000 |=> block_count_o == {1'b0, $past(blk_len_word_i)})
      else $error("block length mis-decoded");
   chk_start_gate: assert property (
      1'b1 |=> (start_o & ~$past(en_flat)) == '0)
      else $error("start from a disabled source");
   chk_start_pass: assert property (
      (src_req_i & en_flat) != '0 && !blocked && !manual_rst_i
      |=> start_o == $past(src_req_i & en_flat))
      else $error("enabled source did not start");
   chk_standby_clr: assert property (
      standby_i |=> en_flat == '0 && !s_q.soft_start_enable
      && s_q.soft_vector_field == 8'h00)
      else $error("standby did not clear registers");
   chk_rsvd_zero: assert property (
      ack_o && csr_rd_q |-> dat_o[15:11] == 5'b0_0000)
      else $error("reserved status bits not zero");
   chk_nmi_block: assert property (
      nmi_i && !standby_i |=> s_q.nmi_seen_flag && start_o == '0 && !soft_start_o)
      else $error("NMI did not set flag and block");
   chk_nmi_cont: assert property (
      nmi_i && busy_i && nmi_continue_mode_i |=> !abort_o)
      else $error("continue-mode transfer aborted");
   chk_ae_block: assert property (
      s_q.addr_error_flag |=> start_o == '0)
      else $error("start while address error flag set");
   chk_flag_sticky: assert property (
      s_q.nmi_seen_flag && !(wr && adr_i == OFS_CSR) && !standby_i
      |=> s_q.nmi_seen_flag)
      else $error("NMI flag cleared without a write");
   chk_vec_lock: assert property (
      s_q.soft_start_enable && !standby_i |=> $stable(s_q.soft_vector_field))
      else $error("vector changed while soft enable set");
   chk_soft_addr: assert property (
      1'b1 |=> soft_vec_addr_o == 16'h0400 + {8'h00, $past(s_q.soft_vector_field)})
      else $error("soft vector address wrong");
   chk_irq_clear: assert property (
      (src_irq_passed_i & en_flat) != '0 && !wr && !standby_i
      |=> (en_flat & $past(src_irq_passed_i)) == '0)
      else $error("enable not cleared after interrupt");
   chk_soft_clear: assert property (
      soft_done_i && !soft_transfer_done_irq_i && !wr |=> !s_q.soft_start_enable)
      else $error("soft enable kept without done interrupt");
   chk_ack_drop: assert property (
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   // Register access: ack, flag stickiness, soft enable set, enable snapshot, vector write, manual reset
   chk_ack_once: assert property (
      req |=> ack_o)
      else $error("request not answered in one cycle");
   chk_ae_sticky: assert property (
      s_q.addr_error_flag && !(wr && adr_i == OFS_CSR) && !standby_i
      |=> s_q.addr_error_flag)
      else $error("address error flag cleared without a write");
   chk_swen_set: assert property (
      wr && adr_i == OFS_CSR && sel_i[1] && dat_i[CSR_SWEN_POS] && !standby_i
      |=> s_q.soft_start_enable)
      else $error("soft enable not set by a write of one");
   chk_en_nosnap: assert property (
      wr && adr_i == OFS_EN_A && !s_q.en_snap_v[0] && !standby_i
      && src_irq_passed_i[7:0] == 8'h00 |=> $stable(s_q.en[0]))
      else $error("enable changed without a prior read");
   chk_vec_write: assert property (
      wr && adr_i == OFS_CSR && sel_i[0] && !s_q.soft_start_enable && !standby_i
      |=> s_q.soft_vector_field == $past(dat_i[7:0]))
      else $error("vector write lost while soft enable clear");
   chk_manual_keep: assert property (
      manual_rst_i && !standby_i && !wr && (src_irq_passed_i & en_flat) == '0
      |=> $stable(en_flat))
      else $error("manual reset altered the enables");

   // Activation gating by the flags and NMI stop of a plain transfer
   chk_soft_block: assert property (
      s_q.nmi_seen_flag || s_q.addr_error_flag |=> !soft_start_o)
      else $error("soft start while a flag is set");
   chk_abort_pass: assert property (
      nmi_i && busy_i && !nmi_continue_mode_i && !manual_rst_i |=> abort_o)
      else $error("plain transfer not stopped by NMI");

   cov_nmi_abort: cover property (nmi_i && busy_i && !nmi_continue_mode_i ##1 abort_o);
   cov_soft_start: cover property (soft_start_o);
   cov_en_write: cover property (wr && adr_i == OFS_EN_A ##1 en_flat[7:0] != 8'h00);
   cov_flag_clear: cover property (s_q.addr_error_flag ##1 !s_q.addr_error_flag);
   cov_nmi_cont: cover property (nmi_i && busy_i && nmi_continue_mode_i);
endmodule
`default_nettype wire

// File: transfer_controller_pkg.sv
/*
 Constants for the transfer controller activation and status block.
 Assumes a 32-bit classic Wishbone register bus with byte addressing.
*/
package transfer_controller_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] OFS_EN_A = 8'h00;
   localparam logic [7:0] OFS_EN_B = 8'h04;
   localparam logic [7:0] OFS_EN_C = 8'h08;
   localparam logic [7:0] OFS_EN_D = 8'h0C;
   localparam logic [7:0] OFS_EN_E = 8'h10;
   localparam logic [7:0] OFS_CSR = 8'h14;
   localparam logic [7:0] OFS_BASE = 8'h18;

   // Sizes of the enable array
   localparam int EN_REGS = 5;
   localparam int EN_BITS = 8;
   localparam int SRC_NUM = EN_REGS * EN_BITS;

   // Control/status field positions
   localparam int CSR_NMI_POS = 10;
   localparam int CSR_AE_POS = 9;
   localparam int CSR_SWEN_POS = 8;
   localparam int CSR_RSVD_LSB = 11;
   localparam int CSR_RSVD_MSB = 15;

   // Reset values
   localparam logic [7:0] EN_RST = 8'h00;
   localparam logic [15:0] CSR_RST = 16'h0000;

   // Software vector table origin and block length limits
   localparam logic [15:0] SOFT_VEC_ORIGIN = 16'h0400;
   localparam logic [15:0] BLK_LEN_WRAP_CODE = 16'h0000;
   localparam logic [16:0] BLK_LEN_WRAP_COUNT = 17'h1_0000;
   localparam int VEC_ENTRY_BYTES = 2;
endpackage

// File: event_source_model.sv
/*
 Model of the interrupt sources and the sequencer status around the block.
 Assumes the testbench calls its tasks; outputs change at rising clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module event_source_model (
   input wire logic clk_i,
   output logic [transfer_controller_pkg::SRC_NUM-1:0] src_req_o,
   output logic [transfer_controller_pkg::SRC_NUM-1:0] src_irq_passed_o,
   output logic nmi_o,
   output logic addr_err_o,
   output logic busy_o,
   output logic nmi_continue_mode_o,
   output logic soft_req_o,
   output logic soft_done_o,
   output logic soft_transfer_done_irq_o,
   output logic [15:0] blk_len_word_o
);
   import transfer_controller_pkg::*;
   // Quiet sources at time zero
   initial begin
      src_req_o = '0;
      src_irq_passed_o = '0;
      {nmi_o, addr_err_o, busy_o, nmi_continue_mode_o} = 4'h0;
      {soft_req_o, soft_done_o, soft_transfer_done_irq_o} = 3'h0;
      blk_len_word_o = 16'h0000;
   end
   // One-cycle event: ev is nmi, ae, busy, continue, soft req, soft done, done irq
   task automatic event_pulse(input logic [SRC_NUM-1:0] req, input logic [SRC_NUM-1:0] pass,
                              input logic [6:0] ev);
      @(posedge clk_i);
      src_req_o <= req;
      src_irq_passed_o <= pass;
      {nmi_o, addr_err_o, busy_o, nmi_continue_mode_o} <= ev[6:3];
      {soft_req_o, soft_done_o, soft_transfer_done_irq_o} <= ev[2:0];
      @(posedge clk_i);
      src_req_o <= '0;
      src_irq_passed_o <= '0;
      {nmi_o, addr_err_o, busy_o, nmi_continue_mode_o} <= 4'h0;
      {soft_req_o, soft_done_o, soft_transfer_done_irq_o} <= 3'h0;
   endtask
   // Block length word fetched from memory, held until the next call
   task automatic set_len(input logic [15:0] w);
      @(posedge clk_i);
      blk_len_word_o <= w;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// File: testbench.sv
/*
 Self-checking bench for the activation and status registers.
 Assumes the event model drives every source and sequencer input.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import transfer_controller_pkg::*;
   localparam int LIMIT = 20000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic standby_i = 1'b0;
   logic manual_rst_i = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] dat_o, rd;
   logic ack_o, nmi, ae, busy, cont, sreq, sdone, sirq, soft_start_o, abort_o;
   logic [SRC_NUM-1:0] src_req, irq_passed, start_o;
   logic [SRC_NUM-1:0] en_exp = '0;
   logic [15:0] blk_len, soft_vec_addr_o, info_base_upper_o;
   logic [16:0] block_count_o;
   logic [15:0] lens [3] = '{16'h0000, 16'h0001, 16'hFFFF};
   logic [7:0] ea;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   // Clock
   always #5 clk_i = ~clk_i;
   transfer_controller_activation_regs dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .standby_i(standby_i), .manual_rst_i(manual_rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .src_req_i(src_req), .src_irq_passed_i(irq_passed), .nmi_i(nmi), .addr_err_i(ae),
      .busy_i(busy), .nmi_continue_mode_i(cont), .soft_req_i(sreq), .soft_done_i(sdone),
      .soft_transfer_done_irq_i(sirq), .blk_len_word_i(blk_len), .start_o(start_o),
      .soft_start_o(soft_start_o), .abort_o(abort_o), .soft_vec_addr_o(soft_vec_addr_o),
      .info_base_upper_o(info_base_upper_o), .block_count_o(block_count_o));
   event_source_model model_u (.clk_i(clk_i), .src_req_o(src_req),
      .src_irq_passed_o(irq_passed), .nmi_o(nmi), .addr_err_o(ae), .busy_o(busy),
      .nmi_continue_mode_o(cont), .soft_req_o(sreq), .soft_done_o(sdone),
      .soft_transfer_done_irq_o(sirq), .blk_len_word_o(blk_len));
   // Verdict and end of run
   task automatic stop_test();
      if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Compare and report
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Classic Wishbone single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000, 4'hF);
      chk(rd, exp);
   endtask
   // Hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         failures++;
         stop_test();
      end
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int r = 0; r < EN_REGS; r++) begin
         ea = OFS_EN_A + 8'(4 * r);
         en_exp[8*r +: 8] = 8'hA5 ^ 8'(r);
         wb(1'b1, ea, 32'h0000_00FF, 4'h1);
         rd_chk(ea, 32'h0000_0000);
         wb(1'b1, ea, {24'h00_0000, en_exp[8*r +: 8]}, 4'h1);
         rd_chk(ea, {24'h00_0000, en_exp[8*r +: 8]});
      end
      rd_chk(OFS_EN_B, {24'h00_0000, en_exp[15:8]});
      wb(1'b1, OFS_EN_B, 32'h0000_000F, 4'h1);
      en_exp[15:8] = 8'h0F;
      rd_chk(OFS_EN_B, 32'h0000_000F);
      model_u.event_pulse('1, '0, 7'h00);
      #1 chk(start_o, en_exp);
      model_u.event_pulse('0, 40'h00_0000_0001, 7'h00);
      en_exp[0] = 1'b0;
      rd_chk(OFS_EN_A, {24'h00_0000, en_exp[7:0]});
      rd_chk(OFS_CSR, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         model_u.set_len(lens[i]);
         #1 chk(block_count_o, (lens[i] == 16'h0000) ? 17'h1_0000 : {1'b0, lens[i]});
      end
      // NMI stops a plain transfer, flag blocks starts
      model_u.event_pulse('0, '0, 7'h50);
      #1 chk(abort_o, 1'b1);
      rd_chk(OFS_CSR, 32'h0000_0400);
      model_u.event_pulse('1, '0, 7'h00);
      #1 chk(start_o, '0);
      model_u.event_pulse('0, '0, 7'h58);
      #1 chk(abort_o, 1'b0);
      wb(1'b1, OFS_CSR, 32'h0000_0400, 4'h2);
      rd_chk(OFS_CSR, 32'h0000_0400);
      wb(1'b1, OFS_CSR, 32'h0000_0000, 4'h2);
      rd_chk(OFS_CSR, 32'h0000_0000);
      // Address error flag
      model_u.event_pulse('0, '0, 7'h20);
      rd_chk(OFS_CSR, 32'h0000_0200);
      model_u.event_pulse('1, '0, 7'h00);
      #1 chk(start_o, '0);
      wb(1'b1, OFS_CSR, 32'h0000_0000, 4'h2);
      rd_chk(OFS_CSR, 32'h0000_0000);
      model_u.event_pulse('1, '0, 7'h00);
      #1 chk(start_o, en_exp);
      // Software activation enable and vector
      wb(1'b1, OFS_CSR, 32'h0000_0010, 4'h3);
      rd_chk(OFS_CSR, 32'h0000_0010);
      chk(soft_vec_addr_o, 16'h0410);
      model_u.event_pulse('0, '0, 7'h04);
      #1 chk(soft_start_o, 1'b0);
      wb(1'b1, OFS_CSR, 32'h0000_0110, 4'h3);
      wb(1'b1, OFS_CSR, 32'h0000_0020, 4'h3);
      rd_chk(OFS_CSR, 32'h0000_0110);
      model_u.event_pulse('0, '0, 7'h04);
      #1 chk(soft_start_o, 1'b1);
      model_u.event_pulse('0, '0, 7'h03);
      rd_chk(OFS_CSR, 32'h0000_0110);
      wb(1'b1, OFS_CSR, 32'h0000_0010, 4'h3);
      rd_chk(OFS_CSR, 32'h0000_0010);
      wb(1'b1, OFS_CSR, 32'h0000_0110, 4'h3);
      model_u.event_pulse('0, '0, 7'h02);
      rd_chk(OFS_CSR, 32'h0000_0010);
      // Base register, manual reset, standby
      wb(1'b1, OFS_BASE, 32'h0000_1234, 4'h3);
      rd_chk(OFS_BASE, 32'h0000_1234);
      chk(info_base_upper_o, 16'h1234);
      @(posedge clk_i);
      manual_rst_i <= 1'b1;
      model_u.event_pulse('1, '0, 7'h00);
      #1 chk(start_o, '0);
      @(posedge clk_i);
      manual_rst_i <= 1'b0;
      rd_chk(OFS_EN_A, {24'h00_0000, en_exp[7:0]});
      rd_chk(OFS_CSR, 32'h0000_0010);
      @(posedge clk_i);
      standby_i <= 1'b1;
      @(posedge clk_i);
      standby_i <= 1'b0;
      rd_chk(OFS_EN_A, 32'h0000_0000);
      rd_chk(OFS_CSR, 32'h0000_0000);
      rd_chk(OFS_BASE, 32'h0000_1234);
      // Power-on reset in mid-run keeps the base register
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(OFS_BASE, 32'h0000_1234);
      rd_chk(OFS_CSR, 32'h0000_0000);
      chk(soft_vec_addr_o, 16'h0400);
      rd_chk(8'h1C, 32'h0000_0000);
      stop_test();
   end
endmodule
`default_nettype wire
